// ==== hw/xbd_ram.sv ====
`timescale 1ns/10ps
module xbd_ram
  import xbd_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_en,
  input  wire logic [1:0]  i_be,
  input  wire logic        i_we,
  input  wire logic [9:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);
  // one array per byte lane so byte writes keep the other half
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      logic [7:0] mem_r [XBD_ERAM_WORDS];
      logic [7:0] rd_r;
      always_ff @(posedge i_clk_sys) begin
        if (i_en && i_we && i_be[g]) begin
          mem_r[i_addr] <= i_wdata[g*8 +: 8];
        end
        if (i_en) begin
          rd_r <= mem_r[i_addr];
        end
      end
      assign o_rdata[g*8 +: 8] = rd_r;
    end
  endgenerate
endmodule

// ==== hw/xbd_top.sv ====
`timescale 1ns/10ps
// Contract
// [RQ1] plain store mode: strobe on every external write
// [RQ2] low-byte mode: strobe on low-byte writes (16-bit) or all writes (8-bit)
// [RQ3] wait-request at inactive level inserts waits until active level
// [RQ4] multiplexed modes pulse the address latch output
// [RQ5] boot-source low at reset selects external fetch, high internal
// [RQ6] demux: data low half; high half data on 16-bit, gpio on 8-bit
// [RQ7] mux: AD low; high half address on 8-bit, AD on 16-bit
// [RQ8] address port driven in demux modes and after switch to mux
// [RQ9] one linear 16M byte space, 24-bit addresses
// [RQ10] extension RAM: 16-bit demux, zero waits, byte and word access
// [RQ11] peripheral enable maps E000h-E7FFh to extension RAM
// [RQ12] RAM disabled: that range goes external by matching window
// [RQ13] peripheral enable maps EF00h-EFFFh to CAN module
// [RQ14] CAN: demux, 16-bit, byte allowed, two waits, no tristate wait
// [RQ15] CAN in use limits segment address to 4 lines
// [RQ16] single-chip setting plus four external modes
// [RQ17] read strobe on every external fetch and data read
// [RQ18] demux address on address port; mux shares the shared port
// [RQ19] four windows, higher overrides lower, default otherwise
// [RQ20] wait-request synchronised; one decision per wait cycle
// [RQ21] address latch pulse ends before read or store strobe
module xbd_top
  import xbd_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_boot_source_select_n,
  input  wire logic        i_wait_req,
  input  wire logic [15:0] i_shared_port,
  output logic      [7:0]  o_shared_port_low_half,
  output logic      [7:0]  o_shared_port_high_half,
  output logic      [15:0] o_shared_port_oe,
  output logic      [7:0]  o_address_port_low_half,
  output logic      [7:0]  o_address_port_high_half,
  output logic             o_address_port_oe,
  output logic      [7:0]  o_segment_addr,
  output logic             o_addr_latch,
  output logic             o_read_strobe_b,
  output logic             o_store_strobe_b,
  output logic             o_boot_external,
  output logic      [15:0] o_can_addr,
  output logic             o_can_sel
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_r, rst_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_r    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_r    <= rst_s1_r;
    end
  end
  wire rst_n = rst_r;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  syscfg_r;
  logic [15:0] buscfg_r [XBD_NWIN+1];
  logic [15:0] winsel_r [XBD_NWIN+1];
  logic [23:0] req_addr_r;
  logic [15:0] req_wdata_r, rdata_r;
  logic [1:0]  req_be_r;
  logic        req_we_r, req_fetch_r, busy_r, err_r, boot_ext_r, boot_taken_r;
  logic        demux_seen_r;
  xbd_state_t  st_r;

  wire apb_wr = psel && penable && pwrite;
  wire apb_go = apb_wr && (paddr == XBD_REQ_OFS) && !busy_r;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syscfg_r <= XBD_SYSCFG_RST;
    end else if (apb_wr && paddr == XBD_SYSCFG_OFS) begin
      syscfg_r <= pwdata[7:0];
    end
  end

  genvar w;
  generate
    for (w = 0; w <= XBD_NWIN; w++) begin : g_win
      always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          buscfg_r[w] <= XBD_BUSCFG_RST;
          winsel_r[w] <= XBD_WINSEL_RST;
        end else if (apb_wr && paddr == XBD_BUSCFG0_OFS + 12'(4*w)) begin
          buscfg_r[w] <= pwdata[15:0];
        end else if (apb_wr && w > 0 && paddr == XBD_WINSEL1_OFS + 12'(4*(w-1))) begin
          winsel_r[w] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_addr_r  <= 24'h000000;
      req_wdata_r <= 16'h0000;
    end else if (apb_wr && paddr == XBD_ADDR_OFS && !busy_r) begin
      req_addr_r  <= pwdata[23:0]; // RQ9
    end else if (apb_wr && paddr == XBD_WDATA_OFS && !busy_r) begin
      req_wdata_r <= pwdata[15:0];
    end
  end

  // boot strap caught once after release, never in the reset branch
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_taken_r <= 1'b0;
      boot_ext_r   <= 1'b0;
    end else if (!boot_taken_r) begin
      boot_taken_r <= 1'b1;
      boot_ext_r   <= !i_boot_source_select_n; // RQ5
    end
  end
  assign o_boot_external = boot_ext_r;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // winsel: [15:4] base (addr[23:12]), [3:0] size code = 2^n pages
  function automatic logic win_hit(input logic [15:0] sel, input logic [23:0] a);
    logic [11:0] msk;
    msk = 12'hFFF << sel[3:0];
    return ((a[23:12] & msk) == (sel[15:4] & msk));
  endfunction

  xbd_tgt_t  tgt;
  xbd_bcfg_t bcfg;
  logic [15:0] cfg_raw;
  wire periph_en = syscfg_r[XBD_SYS_PERIPH_BIT];
  wire eram_en   = periph_en && syscfg_r[XBD_SYS_ERAM_BIT];
  always_comb begin
    cfg_raw = buscfg_r[0];
    // later (higher) windows override earlier ones
    for (int i = 1; i <= XBD_NWIN; i++) begin
      if (buscfg_r[i][XBD_BC_ACT_BIT] && win_hit(winsel_r[i], req_addr_r)) begin
        cfg_raw = buscfg_r[i]; // RQ19 RQ12
      end
    end
    bcfg.active  = cfg_raw[XBD_BC_ACT_BIT];
    bcfg.rdy_en  = cfg_raw[XBD_BC_RDYEN];
    bcfg.rdy_pol = cfg_raw[XBD_BC_RPOL];
    bcfg.waits   = cfg_raw[XBD_BC_WAIT_LSB +: 4];
    bcfg.mode    = xbd_mode_t'(cfg_raw[XBD_BC_MODE_LSB +: 2]);
    if (periph_en && req_addr_r >= XBD_CAN_LO && req_addr_r <= XBD_CAN_HI) begin
      tgt = XBD_T_CAN; // RQ13
    end else if (eram_en && req_addr_r >= XBD_ERAM_LO && req_addr_r <= XBD_ERAM_HI) begin
      tgt = XBD_T_ERAM; // RQ11
    end else if (bcfg.active) begin
      tgt = XBD_T_EXT;
    end else begin
      tgt = XBD_T_NONE; // RQ16 single-chip: no external access
    end
  end

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  logic      wait_s1_r, wait_s2_r;
  logic [3:0] wcnt_r;
  xbd_tgt_t  tgt_r;
  xbd_bcfg_t bcfg_r;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
    end else begin
      wait_s1_r <= i_wait_req; // RQ20
      wait_s2_r <= wait_s1_r;
    end
  end
  wire rdy_ok = !bcfg_r.rdy_en || (wait_s2_r == bcfg_r.rdy_pol); // RQ3
  wire is_mux = (bcfg_r.mode == XBD_M_MUX16) || (bcfg_r.mode == XBD_M_MUX8);
  wire is_8b  = (bcfg_r.mode == XBD_M_MUX8) || (bcfg_r.mode == XBD_M_DMUX8);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= XBD_S_IDLE;
      busy_r   <= 1'b0;
      wcnt_r   <= 4'h0;
      tgt_r    <= XBD_T_NONE;
      bcfg_r   <= '0;
      req_we_r <= 1'b0;
      req_be_r <= 2'h0;
      req_fetch_r <= 1'b0;
    end else begin
      case (st_r)
        XBD_S_IDLE: begin
          if (apb_go) begin
            busy_r      <= 1'b1;
            req_we_r    <= pwdata[0];
            req_be_r    <= pwdata[2:1];
            req_fetch_r <= pwdata[3];
            tgt_r       <= tgt;
            bcfg_r      <= bcfg;
            // internal targets run as 16-bit demux
            if (tgt != XBD_T_EXT) begin
              bcfg_r.mode   <= XBD_M_DMUX16; // RQ10 RQ14
              bcfg_r.rdy_en <= 1'b0;
            end
            wcnt_r <= (tgt == XBD_T_CAN) ? XBD_CAN_WAITS : // RQ14
                      (tgt == XBD_T_EXT) ? bcfg.waits : 4'h0; // RQ10
            if (tgt == XBD_T_NONE) begin
              st_r <= XBD_S_DONE;
            end else if (tgt == XBD_T_EXT && (bcfg.mode == XBD_M_MUX16 ||
                         bcfg.mode == XBD_M_MUX8)) begin
              st_r <= XBD_S_ALE; // RQ4
            end else begin
              st_r <= XBD_S_STRB;
            end
          end
        end
        XBD_S_ALE: st_r <= XBD_S_STRB; // RQ21
        XBD_S_STRB: begin
          if (wcnt_r != 4'h0) begin
            wcnt_r <= wcnt_r - 4'h1;
          end else if (rdy_ok) begin
            st_r <= XBD_S_DONE;
          end else begin
            st_r <= XBD_S_WAIT;
          end
        end
        XBD_S_WAIT: begin
          if (rdy_ok) begin
            st_r <= XBD_S_DONE; // RQ3 RQ20
          end
        end
        XBD_S_DONE: begin
          st_r   <= XBD_S_IDLE;
          busy_r <= 1'b0;
        end
        default: st_r <= XBD_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // extension ram and read capture
  // ----------------------------------------------------------------
  logic [15:0] ram_rd;
  wire ram_go = (st_r == XBD_S_STRB) && (tgt_r == XBD_T_ERAM);
  xbd_ram xbd_ram_inst (
    .i_clk_sys (i_clk_sys),
    .i_en      (ram_go),
    .i_be      (req_be_r),
    .i_we      (req_we_r),
    .i_addr    (req_addr_r[10:1]),
    .i_wdata   (req_wdata_r),
    .o_rdata   (ram_rd)
  );

  // the far side releases the bus with the strobe, so take data at its last edge
  wire strb_end = (st_r == XBD_S_STRB && wcnt_r == 4'h0 && rdy_ok) ||
                  (st_r == XBD_S_WAIT && rdy_ok);
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
      err_r   <= 1'b0;
    end else if (strb_end && tgt_r == XBD_T_EXT && !req_we_r) begin
      rdata_r <= i_shared_port; // RQ17
    end else if (st_r == XBD_S_DONE) begin
      err_r <= (tgt_r == XBD_T_NONE);
      if (!req_we_r && tgt_r != XBD_T_EXT) begin
        rdata_r <= (tgt_r == XBD_T_ERAM) ? ram_rd : 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  wire ext_cyc = (tgt_r == XBD_T_EXT) && (st_r != XBD_S_IDLE) && (st_r != XBD_S_DONE);
  wire strb    = ext_cyc && (st_r == XBD_S_STRB || st_r == XBD_S_WAIT);
  wire lo_wr   = req_be_r[0];
  xbd_port_t sp;
  always_comb begin
    sp = '0;
    if (ext_cyc) begin
      if (st_r == XBD_S_ALE) begin
        sp.out = req_addr_r[15:0]; // RQ7
        sp.oe  = 16'hFFFF;
      end else begin
        if (req_we_r) begin
          sp.out = req_wdata_r; // RQ6
          sp.oe[7:0] = 8'hFF;
        end
        if (is_8b && is_mux) begin
          sp.out[15:8] = req_addr_r[15:8]; // RQ7
          sp.oe[15:8]  = 8'hFF;
        end else if (!is_8b && req_we_r) begin
          sp.oe[15:8]  = 8'hFF; // RQ6 8-bit demux leaves high half as gpio
        end
      end
    end
  end
  assign o_shared_port_low_half  = sp.out[7:0];
  assign o_shared_port_high_half = sp.out[15:8];
  assign o_shared_port_oe        = sp.oe;

  // address port stays driven once a demux mode has been used
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      demux_seen_r <= 1'b0;
    end else if (ext_cyc && !is_mux) begin
      demux_seen_r <= 1'b1; // RQ8
    end
  end
  assign o_address_port_oe = (ext_cyc && !is_mux) || demux_seen_r; // RQ18 RQ8
  assign o_address_port_low_half  = req_addr_r[7:0];
  assign o_address_port_high_half = req_addr_r[15:8];
  assign o_segment_addr = syscfg_r[XBD_SYS_CAN_BIT] ?
                          {4'h0, req_addr_r[16 +: XBD_CAN_SEG_BITS]} : // RQ15
                          req_addr_r[23:16];

  assign o_addr_latch    = ext_cyc && (st_r == XBD_S_ALE); // RQ4 RQ21
  assign o_read_strobe_b = !(strb && !req_we_r); // RQ17
  // low-byte mode: 16-bit bus only on low-byte writes, 8-bit bus always
  assign o_store_strobe_b = !(strb && req_we_r &&
                            (!syscfg_r[XBD_SYS_STMODE_BIT] || is_8b || lo_wr)); // RQ1 RQ2
  assign o_can_sel  = (tgt_r == XBD_T_CAN) && (st_r == XBD_S_STRB); // RQ14
  assign o_can_addr = req_addr_r[15:0];

  // ----------------------------------------------------------------
  // apb read side
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        XBD_SYSCFG_OFS:  prdata <= {24'h000000, syscfg_r};
        XBD_STATUS_OFS:  prdata <= {29'h0, err_r, boot_ext_r, busy_r};
        XBD_BUSCFG0_OFS: prdata <= {16'h0000, buscfg_r[0]};
        XBD_ADDR_OFS:    prdata <= {8'h00, req_addr_r};
        XBD_WDATA_OFS:   prdata <= {16'h0000, req_wdata_r};
        XBD_RDATA_OFS:   prdata <= {16'h0000, rdata_r};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence ale_then_strobe;
    o_addr_latch ##1 (!o_addr_latch && strb);
  endsequence

  ale_order_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ21
    o_addr_latch |-> ale_then_strobe) else $error("latch not followed by strobe");
  ale_mux_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ4
    o_addr_latch |-> is_mux) else $error("latch pulse in demux mode");
  rd_wr_excl_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ17
    !(!o_read_strobe_b && !o_store_strobe_b)) else $error("both strobes active");
  can_wait_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ14
    $rose(o_can_sel) |-> o_can_sel [*3] ##1 !o_can_sel) else $error("can waits wrong");
  plain_wr_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ1
    (strb && req_we_r && !syscfg_r[XBD_SYS_STMODE_BIT]) |-> !o_store_strobe_b)
    else $error("store strobe missing");
  lowbyte_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ2
    (syscfg_r[XBD_SYS_STMODE_BIT] && !is_8b && !lo_wr) |-> o_store_strobe_b)
    else $error("strobe on high byte write");
  wait_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ3
    (st_r == XBD_S_WAIT && !rdy_ok) |=> st_r == XBD_S_WAIT) else $error("wait dropped");
  eram_fast_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ10
    (st_r == XBD_S_STRB && tgt_r == XBD_T_ERAM) |=> st_r == XBD_S_DONE)
    else $error("extension ram not zero wait");
  addr_keep_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n) // RQ8
    demux_seen_r |-> o_address_port_oe) else $error("address port released");
endmodule

// ==== include/xbd_pkg.sv ====
package xbd_pkg;
  // ----------------------------------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] XBD_SYSCFG_OFS  = 12'h000;
  localparam logic [11:0] XBD_STATUS_OFS  = 12'h004;
  localparam logic [11:0] XBD_BUSCFG0_OFS = 12'h010;
  localparam logic [11:0] XBD_WINSEL1_OFS = 12'h020;
  localparam logic [11:0] XBD_BUSCFG1_OFS = 12'h030;
  localparam logic [11:0] XBD_REQ_OFS     = 12'h040;
  localparam logic [11:0] XBD_ADDR_OFS    = 12'h044;
  localparam logic [11:0] XBD_WDATA_OFS   = 12'h048;
  localparam logic [11:0] XBD_RDATA_OFS   = 12'h04C;
  // system config fields
  localparam int XBD_SYS_PERIPH_BIT  = 2;
  localparam int XBD_SYS_ERAM_BIT    = 3;
  localparam int XBD_SYS_STMODE_BIT  = 4;
  localparam int XBD_SYS_CAN_BIT     = 5;
  localparam logic [7:0] XBD_SYSCFG_RST  = 8'h00;
  // bus window config fields
  localparam int XBD_BC_MODE_LSB = 0;   // [1:0] mode
  localparam int XBD_BC_ACT_BIT  = 2;   // window/bus active
  localparam int XBD_BC_RDYEN    = 3;
  localparam int XBD_BC_RPOL     = 4;
  localparam int XBD_BC_WAIT_LSB = 8;   // [11:8] wait states
  localparam logic [15:0] XBD_BUSCFG_RST = 16'h0000;
  localparam logic [15:0] XBD_WINSEL_RST = 16'h0000;
  // fixed on-chip windows and timing
  localparam logic [23:0] XBD_ERAM_LO = 24'h00E000;
  localparam logic [23:0] XBD_ERAM_HI = 24'h00E7FF;
  localparam logic [23:0] XBD_CAN_LO  = 24'h00EF00;
  localparam logic [23:0] XBD_CAN_HI  = 24'h00EFFF;
  localparam logic [3:0]  XBD_CAN_WAITS = 4'h2;
  localparam int XBD_NWIN  = 4;
  localparam int XBD_ERAM_WORDS = 1024;
  localparam int XBD_CAN_SEG_BITS = 4;

  typedef enum logic [1:0] {
    XBD_M_DMUX16 = 2'h0,
    XBD_M_MUX16  = 2'h1,
    XBD_M_MUX8   = 2'h2,
    XBD_M_DMUX8  = 2'h3
  } xbd_mode_t;

  typedef enum logic [2:0] {
    XBD_S_IDLE = 3'h0,
    XBD_S_ALE  = 3'h1,
    XBD_S_STRB = 3'h3,
    XBD_S_WAIT = 3'h2,
    XBD_S_DONE = 3'h6
  } xbd_state_t;

  typedef enum logic [1:0] {
    XBD_T_EXT  = 2'h0,
    XBD_T_ERAM = 2'h1,
    XBD_T_CAN  = 2'h2,
    XBD_T_NONE = 2'h3
  } xbd_tgt_t;

  typedef struct packed {
    logic        active;
    logic        rdy_en;
    logic        rdy_pol;
    logic [3:0]  waits;
    xbd_mode_t   mode;
  } xbd_bcfg_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } xbd_port_t;
endpackage

// ==== verification/xbd_ext_mem.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// external memory on the parallel bus
// ----------------------------------------
module xbd_ext_mem (
  input  wire logic        i_clk_sys,
  input  wire logic        i_read_strobe_b,
  input  wire logic        i_store_strobe_b,
  input  wire logic [15:0] i_data,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rdy_pol,
  input  wire logic [3:0]  i_rdy_delay,
  output logic      [15:0] o_data,
  output logic             o_wait_req
);
  logic [15:0] mem_r [16];
  logic [15:0] last_r;
  logic [3:0]  cnt_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_store_strobe_b) begin
      mem_r[i_addr[4:1]] <= i_data;
    end
    if (!i_read_strobe_b) begin
      last_r <= mem_r[i_addr[4:1]];
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_read_strobe_b || !i_store_strobe_b) begin
      cnt_r <= (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
    end else begin
      cnt_r <= 4'h0;
    end
  end
  // slow device: inactive level until its delay has run out
  assign o_wait_req = (cnt_r >= i_rdy_delay) ? i_rdy_pol : ~i_rdy_pol;
  // released bus shows the inverse, never a stale value
  assign o_data = !i_read_strobe_b ? mem_r[i_addr[4:1]] : ~last_r;
endmodule

// ==== verification/xbd_top_tb.sv ====
`timescale 1ns/10ps
module xbd_top_tb;
  import xbd_pkg::*;
  logic clk = 1'b0, rst_b, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, wreq, boot_n = 1'b0, rdy_pol = 1'b1;
  logic [3:0] rdy_delay = 4'h0;
  logic [15:0] sp_in, sp_oe, st_d, st_oe, ale_a, sa;
  logic [7:0] spl, sph, apl, aph, seg, seg_r;
  logic ap_oe, ale, rd_b, st_b, boot_ext, can_sel, sa_oe;
  logic [15:0] can_addr;
  int num_errors = 0, samples_checked = 0, st_n, rd_n, ale_n, can_n, ovl, n0;
  always #50 clk = ~clk;
  xbd_top xbd_top_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_boot_source_select_n(boot_n), .i_wait_req(wreq),
    .i_shared_port(sp_in), .o_shared_port_low_half(spl), .o_shared_port_high_half(sph),
    .o_shared_port_oe(sp_oe), .o_address_port_low_half(apl),
    .o_address_port_high_half(aph), .o_address_port_oe(ap_oe), .o_segment_addr(seg),
    .o_addr_latch(ale), .o_read_strobe_b(rd_b), .o_store_strobe_b(st_b),
    .o_boot_external(boot_ext), .o_can_addr(can_addr), .o_can_sel(can_sel));
  xbd_ext_mem xbd_ext_mem_inst (.i_clk_sys(clk), .i_read_strobe_b(rd_b),
    .i_store_strobe_b(st_b), .i_data({sph, spl}), .i_addr({aph, apl}),
    .i_rdy_pol(rdy_pol), .i_rdy_delay(rdy_delay), .o_data(sp_in), .o_wait_req(wreq));
  // ----------------------------------------
  // bus watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (!st_b || !rd_b) begin
      sa = {aph, apl};
      sa_oe = ap_oe;
    end
    if (!st_b) begin
      st_n++;
      st_d = {sph, spl};
      st_oe = sp_oe;
      seg_r = seg;
    end
    if (!rd_b) rd_n++;
    if (can_sel) can_n++;
    if (ale) begin
      ale_n++;
      ale_a = {sph, spl};
      if (!st_b || !rd_b) ovl++;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] sys, input logic [15:0] bc);
    apb(1'b1, XBD_SYSCFG_OFS, {24'h0, sys});
    apb(1'b1, XBD_BUSCFG0_OFS, {16'h0, bc});
  endtask
  task automatic xfer(input logic [3:0] req, input logic [23:0] a, input logic [15:0] d);
    int i;
    st_n = 0; rd_n = 0; ale_n = 0; can_n = 0; ovl = 0;
    apb(1'b1, XBD_ADDR_OFS, {8'h0, a});
    apb(1'b1, XBD_WDATA_OFS, {16'h0, d});
    apb(1'b1, XBD_REQ_OFS, {28'h0, req});
    for (i = 0; i < 100; i++) begin
      apb(1'b0, XBD_STATUS_OFS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk("busy", 0, q[0]);
    apb(1'b0, XBD_RDATA_OFS, 32'h0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_demux;
    cfg(8'h00, 16'h0004);
    xfer(4'h7, 24'h001234, 16'hA55A);
    chk("store", 1, st_n > 0);
    chk("addr port", 16'h1234, sa);
    chk("data", 16'hA55A, st_d);
    chk("oe16", 16'hFFFF, st_oe);
    chk("no ale", 0, ale_n);
    xfer(4'h6, 24'h001234, 16'h0);
    chk("read", 1, rd_n > 0 && st_n == 0);
    chk("rdata", 16'hA55A, q[15:0]);
    xfer(4'hE, 24'h001234, 16'h0);
    chk("fetch", 1, rd_n > 0);
    xfer(4'h5, 24'h001234, 16'h7700);
    chk("store byte", 1, st_n > 0);
    cfg(8'h00, 16'h0007);
    xfer(4'h7, 24'h001234, 16'h00C3);
    chk("oe8", 8'h00, st_oe[15:8]);
  endtask
  task automatic t_mux;
    cfg(8'h00, 16'h0005);
    xfer(4'h7, 24'h002468, 16'h1357);
    chk("ale", 1, ale_n);
    chk("ale addr", 16'h2468, ale_a);
    chk("ale first", 0, ovl);
    chk("addr port mux", 16'h2468, sa);
    chk("addr oe mux", 1, sa_oe);
    cfg(8'h00, 16'h0006);
    xfer(4'h7, 24'h002468, 16'h0013);
    chk("a8 a15", 8'h24, st_d[15:8]);
    chk("ale8", 1, ale_n);
  endtask
  task automatic t_lowbyte;
    cfg(8'h10, 16'h0004);
    xfer(4'h5, 24'h000010, 16'h1100);
    chk("hi byte", 0, st_n);
    xfer(4'h3, 24'h000010, 16'h0011);
    chk("lo byte", 1, st_n > 0);
    cfg(8'h10, 16'h0007);
    xfer(4'h7, 24'h000010, 16'h0022);
    chk("8bit", 1, st_n > 0);
  endtask
  task automatic t_onchip;
    cfg(8'h0C, 16'h0004);
    xfer(4'h7, 24'h00E010, 16'hBEEF);
    chk("ram int", 0, st_n + rd_n);
    xfer(4'h5, 24'h00E010, 16'h1200);
    xfer(4'h6, 24'h00E010, 16'h0);
    chk("ram byte", 16'h12EF, q[15:0]);
    cfg(8'h04, 16'h0004);
    xfer(4'h7, 24'h00E010, 16'h0001);
    chk("ram off", 1, st_n > 0);
    cfg(8'h24, 16'h0004);
    xfer(4'h6, 24'h00EF00, 16'h0);
    chk("can int", 0, st_n + rd_n);
    chk("can waits", 3, can_n);
    xfer(4'h7, 24'h5A1234, 16'h0002);
    chk("seg", 8'h0A, seg_r);
  endtask
  task automatic t_ready;
    cfg(8'h00, 16'h001C);
    xfer(4'h7, 24'h000020, 16'h0003);
    n0 = st_n;
    rdy_delay <= 4'h5;
    xfer(4'h7, 24'h000020, 16'h0004);
    chk("wait hi", 1, st_n >= n0 + 5);
    rdy_pol <= 1'b0;
    cfg(8'h00, 16'h000C);
    xfer(4'h7, 24'h000020, 16'h0005);
    chk("wait lo", 1, st_n >= n0 + 5);
    rdy_delay <= 4'h0;
  endtask
  task automatic t_single;
    cfg(8'h00, 16'h0000);
    xfer(4'h7, 24'h000030, 16'h0006);
    chk("single", 0, st_n + rd_n);
    apb(1'b0, XBD_STATUS_OFS, 32'h0);
    chk("err", 1'b1, q[2]);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_reboot;
    boot_n <= 1'b1;
    rst_b  <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("boot int", 1'b0, boot_ext);
    apb(1'b0, XBD_SYSCFG_OFS, 32'h0);
    chk("syscfg rst2", 32'h0, q);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(100 * 30000);
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("boot ext", 1'b1, boot_ext);
    apb(1'b0, XBD_SYSCFG_OFS, 32'h0);
    chk("syscfg rst", 32'h0, q);
    t_demux();
    t_mux();
    t_lowbyte();
    t_onchip();
    t_ready();
    t_single();
    t_reboot();
    print_verdict();
  end
endmodule
